// >>> dtar_top.sv
/*
 * Adjustment rate configuration byte with APB access and two channel wait timers.
 * Assumes an APB master on pclk; dir inputs come from the fan control loop.
 */
// The implementer's own choice: register access over APB.
// Behaviour
// - Bits 2:0 set remote 1 wait: 8..1024 decrease, 16..2048 increase cycles.
// - Bits 5:3 set remote 2 wait with the same doubling table.
// - Waits count monitoring cycles, eight per second.
// - Bit 6 is a writable loop select bit, default one.
// - Power-on value of the byte is 0x40.
// - Software reset restores 0x40, even when locked; lock blocks further rate and enable writes.
// - A channel adjusts only while its enable bit is set; enables default off.
`include "dtar_params.svh"
`default_nettype none
module dtar_top #(
	parameter int TICK_CLKS = `DTAR_MON_TICK_CLKS
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic r1_increase,
	input wire logic r2_increase,
	output logic loop_select,
	output logic r1_adjust,
	output logic r2_adjust
);
	// ----------------------------------------------------------------------
	// State
	// ----------------------------------------------------------------------
	typedef struct packed {
		logic [7:0] rate;
		logic en1;
		logic en2;
		logic lock;
		logic [23:0] div;
		logic tick;
		logic [31:0] rdata;
		logic ready;
		logic err;
		logic loop_sel;
		logic adj1;
		logic adj2;
	} dtar_top_s;

	dtar_top_s s_q;
	dtar_top_s s_d;
	logic setup;
	logic wr;
	logic t1_adj;
	logic t2_adj;

	dtar_wait_if w1();
	dtar_wait_if w2();

	function automatic logic is_mapped(input logic [11:0] a);
		is_mapped = (a == `DTAR_OFF_RATE) || (a == `DTAR_OFF_CTRL) || (a == `DTAR_OFF_STAT);
	endfunction

	// One-cycle slave: the setup cycle is decoded and pready rises in the access cycle.
	assign setup = psel && !penable;
	assign wr = psel && penable && s_q.ready && pwrite && !s_q.err;

	// ----------------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------------
	always_comb
	begin
		s_d = s_q;
		s_d.ready = setup;
		s_d.err = setup && !is_mapped(paddr);
		s_d.tick = 1'b0;
		if (s_q.div == 24'(TICK_CLKS - 1))
		begin
			s_d.div = '0;
			s_d.tick = 1'b1;
		end
		else
		begin
			s_d.div = s_q.div + 24'h000001;
		end
		if (setup && !pwrite)
		begin
			s_d.rdata = '0;
			if (paddr == `DTAR_OFF_RATE)
			begin
				s_d.rdata = {24'h000000, 1'b0, s_q.rate[6:0]};
			end
			else if (paddr == `DTAR_OFF_CTRL)
			begin
				s_d.rdata = {28'h0000000, 1'b0, s_q.lock, s_q.en2, s_q.en1};
			end
			else if (paddr == `DTAR_OFF_STAT)
			begin
				s_d.rdata = {29'h00000000, s_q.loop_sel, s_q.adj2, s_q.adj1};
			end
		end
		if (wr && paddr == `DTAR_OFF_RATE && !s_q.lock)
		begin
			s_d.rate = {1'b0, pwdata[6:0]};
		end
		if (wr && paddr == `DTAR_OFF_CTRL)
		begin
			if (pwdata[`DTAR_CTRL_SWRST])
			begin
				s_d.rate = `DTAR_RATE_RESET;
				s_d.en1 = 1'b0;
				s_d.en2 = 1'b0;
			end
			else if (!s_q.lock)
			begin
				s_d.en1 = pwdata[`DTAR_CTRL_EN1];
				s_d.en2 = pwdata[`DTAR_CTRL_EN2];
			end
			// The lock is sticky until power-on reset, as a lock should be.
			s_d.lock = s_q.lock | pwdata[`DTAR_CTRL_LOCK];
		end
		s_d.loop_sel = s_d.rate[`DTAR_LOOP_BIT];
		s_d.adj1 = t1_adj;
		s_d.adj2 = t2_adj;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_q <= '0;
			s_q.rate <= `DTAR_RATE_RESET;
			s_q.loop_sel <= 1'b1;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------------
	// Channel timers
	// ----------------------------------------------------------------------
	// Both channels share one monitoring tick, so their waits count in the same unit.
	assign w1.enable = s_q.en1;
	assign w1.code = s_q.rate[`DTAR_R1_LSB +: 3];
	assign w1.dir = r1_increase ? dtar_pkg::DTAR_DIR_INC : dtar_pkg::DTAR_DIR_DEC;
	assign w1.tick = s_q.tick;
	assign t1_adj = w1.adjust;
	assign w2.enable = s_q.en2;
	assign w2.code = s_q.rate[`DTAR_R2_LSB +: 3];
	assign w2.dir = r2_increase ? dtar_pkg::DTAR_DIR_INC : dtar_pkg::DTAR_DIR_DEC;
	assign w2.tick = s_q.tick;
	assign t2_adj = w2.adjust;

	dtar_wait_timer #(.CNT_W(12)) u_t1 (.pclk(pclk), .presetn(presetn), .wif(w1));
	dtar_wait_timer #(.CNT_W(12)) u_t2 (.pclk(pclk), .presetn(presetn), .wif(w2));

	assign prdata = s_q.rdata;
	assign pready = s_q.ready;
	assign pslverr = s_q.err;
	assign loop_select = s_q.loop_sel;
	assign r1_adjust = s_q.adj1;
	assign r2_adjust = s_q.adj2;

	// ----------------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------------
	// Each write is recognised at the access edge, where pready is already high.
	sequence wr_rate_s;
		psel && penable && pready && pwrite && !pslverr && paddr == `DTAR_OFF_RATE;
	endsequence

	sequence wr_ctrl_s;
		psel && penable && pready && pwrite && !pslverr && paddr == `DTAR_OFF_CTRL;
	endsequence

	sequence setup_s;
		psel && !penable;
	endsequence

	chk_rate_bit7_zero: assert property (@(posedge pclk) disable iff (!presetn)
		s_q.rate[7] == 1'b0)
		else $error("reserved bit set");
	chk_locked_no_write: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_rate_s and s_q.lock) |=> s_q.rate == $past(s_q.rate))
		else $error("write accepted while locked");
	chk_rate_write: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_rate_s and !s_q.lock) |=> s_q.rate == {1'b0, $past(pwdata[6:0])})
		else $error("rate write lost");
	chk_soft_reset: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_ctrl_s and pwdata[`DTAR_CTRL_SWRST])
		|=> s_q.rate == `DTAR_RATE_RESET && !s_q.en1 && !s_q.en2 ##1 loop_select)
		else $error("soft reset did not restore byte");
	chk_lock_sticky: assert property (@(posedge pclk) disable iff (!presetn)
		s_q.lock |=> s_q.lock)
		else $error("lock released without power-on reset");
	chk_locked_enables: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_ctrl_s and s_q.lock and !pwdata[`DTAR_CTRL_SWRST])
		|=> s_q.en1 == $past(s_q.en1) && s_q.en2 == $past(s_q.en2))
		else $error("enables moved while locked");
	chk_loop_follow: assert property (@(posedge pclk) disable iff (!presetn)
		loop_select == s_q.rate[`DTAR_LOOP_BIT])
		else $error("loop select output stale");
	chk_ready_timing: assert property (@(posedge pclk) disable iff (!presetn)
		setup_s |=> pready ##1 !pready)
		else $error("pready not one cycle after setup");
	chk_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
		setup_s ##0 (paddr != `DTAR_OFF_RATE && paddr != `DTAR_OFF_CTRL
		&& paddr != `DTAR_OFF_STAT)
		|=> pslverr)
		else $error("unmapped access without error");
	chk_no_adj_off: assert property (@(posedge pclk) disable iff (!presetn)
		!s_q.en1 [*3] |-> !r1_adjust)
		else $error("remote 1 adjusted while disabled");
	chk_no_adj2_off: assert property (@(posedge pclk) disable iff (!presetn)
		!s_q.en2 [*3] |-> !r2_adjust)
		else $error("remote 2 adjusted while disabled");
	chk_tick_spacing: assert property (@(posedge pclk) disable iff (!presetn)
		s_q.tick && TICK_CLKS > 1 |=> !s_q.tick)
		else $error("monitor tick too frequent");
	// Reset itself is watched here, so this check has no disable clause.
	chk_reset_byte: assert property (@(posedge pclk)
		!presetn [*2] |-> s_q.rate == `DTAR_RATE_RESET && loop_select)
		else $error("byte not at power-on value in reset");
endmodule
`default_nettype wire

// >>> dtar_params.svh
/*
 * Offsets, field positions, reset values and timing counts of the adjustment rate block.
 * Assumes inclusion by bare name from the block's design files.
 */
`ifndef DTAR_PARAMS_SVH
`define DTAR_PARAMS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define DTAR_OFF_RATE 12'h00c
`define DTAR_OFF_CTRL 12'h010
`define DTAR_OFF_STAT 12'h014
`define DTAR_RATE_RESET 8'h40
`define DTAR_CTRL_RESET 8'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define DTAR_R1_LSB 0
`define DTAR_R2_LSB 3
`define DTAR_LOOP_BIT 6
`define DTAR_CTRL_EN1 0
`define DTAR_CTRL_EN2 1
`define DTAR_CTRL_LOCK 2
`define DTAR_CTRL_SWRST 3

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define DTAR_MIN_DEC_CYCLES 8
`define DTAR_CYCLES_PER_SEC 8
`define DTAR_CLK_HZ 10000000
`define DTAR_MON_TICK_CLKS (`DTAR_CLK_HZ / `DTAR_CYCLES_PER_SEC)

`endif

// >>> dtar_pkg.sv
/*
 * Types shared by the adjustment rate block.
 * Assumes dtar_params.svh is available on the include path.
 */
`default_nettype none
package dtar_pkg;
	typedef enum logic [1:0] {
		DTAR_DIR_DEC = 2'b01,
		DTAR_DIR_INC = 2'b10
	} dtar_dir_e;
endpackage
`default_nettype wire

// >>> dtar_wait_if.sv
/*
 * Carrier between the register file and one per-channel wait timer.
 * Assumes a single clock shared by both ends.
 */
`default_nettype none
interface dtar_wait_if;
	logic enable;
	logic [2:0] code;
	dtar_pkg::dtar_dir_e dir;
	logic tick;
	logic adjust;
	modport ctrl (output enable, output code, output dir, output tick, input adjust);
	modport timer (input enable, input code, input dir, input tick, output adjust);
endinterface
`default_nettype wire

// >>> dtar_wait_timer.sv
/*
 * Counts monitoring cycles for one channel and pulses when an adjustment may be made.
 * Assumes tick is a one-cycle pulse per monitoring cycle.
 */
`include "dtar_params.svh"
`default_nettype none
module dtar_wait_timer #(
	parameter int CNT_W = 12
) (
	input wire logic pclk,
	input wire logic presetn,
	dtar_wait_if.timer wif
);
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic adjust;
	} dtar_tmr_s;

	dtar_tmr_s s_q;
	dtar_tmr_s s_d;
	logic [CNT_W-1:0] limit;

	// Increase waits are one code step longer than decrease waits.
	always_comb
	begin
		limit = CNT_W'(`DTAR_MIN_DEC_CYCLES) << wif.code;
		if (wif.dir == dtar_pkg::DTAR_DIR_INC)
		begin
			limit = limit << 1;
		end
	end

	always_comb
	begin
		s_d = s_q;
		s_d.adjust = 1'b0;
		if (!wif.enable)
		begin
			s_d.cnt = '0;
		end
		else if (wif.tick)
		begin
			if (s_q.cnt + CNT_W'(1) >= limit)
			begin
				s_d.cnt = '0;
				s_d.adjust = 1'b1;
			end
			else
			begin
				s_d.cnt = s_q.cnt + CNT_W'(1);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_q <= '0;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign wif.adjust = s_q.adjust;

	chk_adjust_needs_enable: assert property (@(posedge pclk) disable iff (!presetn)
		s_q.adjust |-> $past(wif.enable) && $past(wif.tick))
		else $error("adjust pulse without enable and tick");
	// A shorter code written once the count has reached the new limit less one ends the running wait at the next tick.
	chk_adjust_at_limit: assert property (@(posedge pclk) disable iff (!presetn)
		s_q.adjust |-> $past(s_q.cnt) >= $past(limit) - CNT_W'(1))
		else $error("adjust pulse before wait elapsed");
	chk_no_early_adjust: assert property (@(posedge pclk) disable iff (!presetn)
		wif.enable && wif.tick && s_q.cnt < limit - CNT_W'(1) |=> !s_q.adjust)
		else $error("adjust pulse ahead of its wait");
endmodule
`default_nettype wire

// >>> dtar_tb.sv
/*
 * Self-checking bench for the adjustment rate block: registers, wait timing, lock, soft reset.
 * Assumes the design files are compiled first and dtar_params.svh is on the include path.
 */
`include "dtar_params.svh"
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_mismatch++; \
	$display("Error at %0t: got %0h expected %0h", $time, a, b); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	// A short monitoring tick keeps the longest wait near eight thousand clocks.
	localparam int TICK = 4;
	typedef struct packed {
		logic wr;
		logic [11:0] addr;
		logic [31:0] wdata;
		logic [31:0] rd;
		logic err;
		logic ls;
	} dtar_tb_row_s;
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic r1_increase = 1'h0;
	logic r2_increase = 1'h0;
	logic loop_select;
	logic r1_adjust;
	logic r2_adjust;
	int n_mismatch = 0;
	int samples_checked = 0;
	int n;
	logic [31:0] rd;
	logic err;
	dtar_tb_row_s rows [10];
	dtar_top #(.TICK_CLKS(TICK)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .r1_increase(r1_increase),
		.r2_increase(r2_increase), .loop_select(loop_select), .r1_adjust(r1_adjust),
		.r2_adjust(r2_adjust));
	always #50 pclk = ~pclk;
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic final_report();
		$display("Checked %0d, mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		for (i = 0; i < 16; i++)
		begin
			@(posedge pclk);
			if (pready === 1'h1)
				break;
		end
		if (i == 16)
		begin
			n_mismatch++;
			final_report();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	// Counts edges up to and including the next adjust pulse of one channel.
	task automatic wait_pulse(input logic ch);
		for (n = 1; n <= 20000; n++)
		begin
			@(posedge pclk);
			if ((ch ? r2_adjust : r1_adjust) === 1'h1)
				return;
		end
		n_mismatch++;
		final_report();
	endtask
	task automatic quiet();
		int hits = 0;
		repeat (300)
		begin
			@(posedge pclk);
			if (r1_adjust !== 1'h0 || r2_adjust !== 1'h0)
				hits++;
		end
		`CHK(hits, 0)
	endtask
	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial
	begin
		rows[0] = {1'h0, `DTAR_OFF_RATE, 32'h0, 24'h0, `DTAR_RATE_RESET, 1'h0, 1'h1};
		rows[1] = {1'h0, `DTAR_OFF_CTRL, 32'h0, 32'h0, 1'h0, 1'h1};
		rows[2] = {1'h0, `DTAR_OFF_STAT, 32'h0, 32'h4, 1'h0, 1'h1};
		rows[3] = {1'h1, `DTAR_OFF_RATE, 32'hff, 32'h0, 1'h0, 1'h1};
		rows[4] = {1'h0, `DTAR_OFF_RATE, 32'h0, 32'h7f, 1'h0, 1'h1};
		rows[5] = {1'h1, `DTAR_OFF_RATE, 32'h2a, 32'h0, 1'h0, 1'h0};
		rows[6] = {1'h0, `DTAR_OFF_RATE, 32'h0, 32'h2a, 1'h0, 1'h0};
		rows[7] = {1'h1, 12'h020, 32'h55, 32'h0, 1'h1, 1'h0};
		rows[8] = {1'h0, 12'h020, 32'h0, 32'h0, 1'h1, 1'h0};
		rows[9] = {1'h0, `DTAR_OFF_RATE, 32'h0, 32'h2a, 1'h0, 1'h0};
		repeat (10) @(posedge pclk);
		`CHK(loop_select, 1'h1)
		presetn <= 1'h1;
		quiet();
		foreach (rows[r])
		begin
			apb(rows[r].wr, rows[r].addr, rows[r].wdata);
			`CHK(err, rows[r].err)
			if (!rows[r].wr)
				`CHK(rd, rows[r].rd)
			repeat (2) @(posedge pclk);
			`CHK(loop_select, rows[r].ls)
		end
		apb(1'h1, `DTAR_OFF_CTRL, 32'h3);
		for (int c = 0; c < 8; c++)
		begin
			r1_increase <= c[0];
			r2_increase <= !c[0];
			apb(1'h1, `DTAR_OFF_RATE, 32'(((7 - c) << `DTAR_R2_LSB) | c));
			wait_pulse(1'h0);
			wait_pulse(1'h0);
			`CHK(n, (`DTAR_MIN_DEC_CYCLES << c) * (c[0] ? 2 : 1) * TICK)
			wait_pulse(1'h1);
			wait_pulse(1'h1);
			`CHK(n, (`DTAR_MIN_DEC_CYCLES << (7 - c)) * (c[0] ? 1 : 2) * TICK)
		end
		// Once locked, neither the rate byte nor the enables may move except by soft reset.
		apb(1'h1, `DTAR_OFF_CTRL, 32'h7);
		apb(1'h1, `DTAR_OFF_RATE, 32'h0);
		apb(1'h1, `DTAR_OFF_CTRL, 32'h4);
		apb(1'h0, `DTAR_OFF_RATE, 32'h0);
		`CHK(rd, 32'h7)
		apb(1'h0, `DTAR_OFF_CTRL, 32'h0);
		`CHK(rd, 32'h7)
		apb(1'h1, `DTAR_OFF_CTRL, 32'hc);
		apb(1'h0, `DTAR_OFF_RATE, 32'h0);
		`CHK(rd, 32'h40)
		apb(1'h0, `DTAR_OFF_CTRL, 32'h0);
		`CHK(rd, 32'h4)
		`CHK(loop_select, 1'h1)
		quiet();
		presetn <= 1'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		apb(1'h0, `DTAR_OFF_CTRL, 32'h0);
		`CHK(rd, 32'h0)
		apb(1'h1, `DTAR_OFF_RATE, 32'h11);
		apb(1'h0, `DTAR_OFF_RATE, 32'h0);
		`CHK(rd, 32'h11)
		final_report();
	end
endmodule
`default_nettype wire
